/* hw/mdio_defines.svh */
// Register map, field positions, reset values and counts for the MDC/MDIO block
`ifndef MDIO_DEFINES_SVH
`define MDIO_DEFINES_SVH

`define IDX_POLL_EN 16'hF40B
`define IDX_CLK_CFG 16'hF40C
`define IDX_PORT0 16'hF415
`define IDX_STATUS 16'hF4F0

`define RST_POLL_EN 7'h6F
`define RST_CLK_CFG 15'h0109
`define RST_PORT0 16'h1800

`define CFG_RST 15
`define CFG_GAP 14:9
`define CFG_EN 8
`define CFG_FREQ 7:0
`define CFG_LOW 14:0

`define P_SEL 15
`define P_LNK 14:13
`define P_SPD 12:11
`define P_DUP 10:9
`define P_FTX 8:7
`define P_FRX 6:5
`define P_ADDR 4:0

`define CODE_AUTO 2'h0
`define LNK_UP 2'h1
`define LNK_DOWN 2'h2
`define SPD_AUTO 2'h3
`define DUP_FULL 2'h1
`define DUP_HALF 2'h3
`define FC_ING 2'h1
`define FC_EGR 2'h3

`define PS_TXP 0
`define PS_RXP 1
`define PS_DUP 2
`define PS_SPD 4:3
`define PS_LNK 5

`define NUM_PORTS 7
`define PRESCALE_LAST 3'h4
`define SRST_CYCLES 4'h8
`define GAP_LSBS 8'h00
`define HDR_BITS 6'h2E
`define DATA_FIRST 6'h30
`define FRAME_LAST 6'h3F
`define PREAMBLE 32'hFFFFFFFF
`define FRAME_ST 2'h1
`define FRAME_RD 2'h2
`define POLL_REG 5'h01

`endif

/* hw/mdio_pkg.sv */
// Types shared by the MDC/MDIO clock and link override block
package mdio_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FRAME = 3'b010,
    ST_GAP = 3'b100
  } poll_state_t;
endpackage

/* hw/mdc_divider.sv */
// Management clock divider: sys_clk / 5 / ((rate + 1) * 2)
`timescale 1ns/10ps
`include "mdio_defines.svh"

module mdc_divider (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic srst,
  input wire logic run,
  input wire logic [7:0] rate,
  output logic tick_rise,
  output logic tick_fall,
  output logic mdc_level
);
  logic [2:0] pre;
  logic [7:0] half;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= 3'h0;
      half <= 8'h00;
      mdc_level <= 1'b0;
      tick_rise <= 1'b0;
      tick_fall <= 1'b0;
    end else if (srst || !run) begin
      pre <= 3'h0;
      half <= 8'h00;
      mdc_level <= 1'b0;
      tick_rise <= 1'b0;
      tick_fall <= 1'b0;
    end else begin
      tick_rise <= 1'b0;
      tick_fall <= 1'b0;
      if (pre == `PRESCALE_LAST) begin
        pre <= 3'h0;
        if (half >= rate) begin
          half <= 8'h00;
          mdc_level <= ~mdc_level; // (RULE4)
          tick_rise <= ~mdc_level;
          tick_fall <= mdc_level;
        end else begin
          half <= half + 8'h01;
        end
      end else begin
        pre <= pre + 3'h1;
      end
    end
  end
endmodule // mdc_divider

/* hw/mdio_clock_and_link_override.sv */
// MDC clock, auto-polling engine and port 0 link override behind APB
//
// Contract
// (RULE1) Soft-reset bit resets MDIO hardware, keeps registers, self-clears when done.
// (RULE2) Wait 256 times gap field MDC cycles between polling reads.
// (RULE3) Clock-driver enable gates MDC; cleared also makes MDIO an input.
// (RULE4) MDC equals system clock over 5 over twice (rate plus one).
// (RULE5) Source select: 0 uses polling results, 1 integrated PHY outputs.
// (RULE6) Link control: 00 auto, 01 forced up, 10 forced down, 11 reserved.
// (RULE7) Speed control: 00 10M, 01 100M, 10 1G, 11 automatic.
// (RULE8) Duplex control: 00 auto, 01 full, 11 half, 10 reserved.
// (RULE9) TX flow mode: 00 auto, 01 ingress only, 11 egress only.
// (RULE10) RX flow mode uses the same encoding as TX flow mode.
// (RULE11) Five-bit PHY address per port, reset from strap, used for access; here only port 0 has one, ports 1-6 use their port number.
// (RULE12) Polling disabled for port: register settings used, not polled values.
// (RULE13) Seven-bit per-port enable; disabled ports are skipped by polling.
// (RULE14) Gap of zero starts the next polling read at once.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`include "mdio_defines.svh"

module mdio_clock_and_link_override (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [17:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] phy_addr_strap,
  input wire logic iphy_link,
  input wire logic [1:0] iphy_speed,
  input wire logic iphy_duplex,
  input wire logic iphy_tx_pause,
  input wire logic iphy_rx_pause,
  output logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic [2:0] poll_port,
  output logic link_up,
  output logic [1:0] link_speed,
  output logic link_full_duplex,
  output logic [1:0] tx_flow_mode,
  output logic [1:0] rx_flow_mode
);
  logic rst_meta;
  logic rst_n;
  logic [14:0] clk_cfg;
  logic [6:0] poll_en;
  logic [15:0] port0;
  logic strap_done;
  logic srst_active;
  logic [3:0] srst_cnt;
  logic tick_rise;
  logic tick_fall;
  logic mdc_level;
  mdio_pkg::poll_state_t state;
  logic [5:0] bit_cnt;
  logic [45:0] hdr_sr;
  logic [15:0] rd_sr;
  logic [13:0] gap_cnt;
  logic [5:0] poll_stat;
  logic run;
  logic [15:0] idx;
  logic wr_access;
  logic [13:0] gap_target;
  logic [2:0] next_port;
  logic [4:0] next_addr;
  logic src_link;
  logic [1:0] src_speed;
  logic src_dup;
  logic src_txp;
  logic src_rxp;

  function automatic logic reg_hit(input logic [15:0] i);
    reg_hit = (i == `IDX_POLL_EN) || (i == `IDX_CLK_CFG) || (i == `IDX_PORT0) ||
              (i == `IDX_STATUS);
  endfunction

  // Returns {egress, ingress}; auto follows the source's pause bit
  function automatic logic [1:0] flow_resolve(input logic [1:0] code, input logic pause);
    unique case (code)
      `FC_ING: flow_resolve = 2'h1;
      `FC_EGR: flow_resolve = 2'h2;
      default: flow_resolve = {pause, pause};
    endcase
  endfunction

  function automatic logic [2:0] pick_port(input logic [6:0] en, input logic [2:0] cur);
    logic [2:0] p;
    pick_port = cur;
    p = cur;
    for (int k = 0; k < `NUM_PORTS; k++) begin
      p = (p == 3'h6) ? 3'h0 : p + 3'h1;
      if (en[p] && pick_port == cur) begin
        pick_port = p;
      end
    end
  endfunction

  // Reset released through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign idx = paddr[17:2];
  assign wr_access = psel && penable && pready && pwrite && reg_hit(idx);
  assign run = clk_cfg[`CFG_EN] && !srst_active;
  assign gap_target = {clk_cfg[`CFG_GAP], `GAP_LSBS};
  assign next_port = pick_port(poll_en, poll_port);
  assign next_addr = (next_port == 3'h0) ? port0[`P_ADDR] : {2'h0, next_port};

  // APB: no wait states, answer in the first access cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !reg_hit(idx);
      if (psel && !penable && !pwrite) begin
        unique case (idx)
          `IDX_POLL_EN: prdata <= {25'h0000000, poll_en};
          `IDX_CLK_CFG: prdata <= {16'h0000, srst_active, clk_cfg};
          `IDX_PORT0: prdata <= {16'h0000, port0};
          `IDX_STATUS: prdata <= {16'h0000, state, poll_port, 4'h0, poll_stat};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_cfg <= `RST_CLK_CFG;
      poll_en <= `RST_POLL_EN;
    end else if (wr_access) begin
      if (idx == `IDX_CLK_CFG) begin
        clk_cfg <= pwdata[`CFG_LOW];
      end
      if (idx == `IDX_POLL_EN) begin
        poll_en <= pwdata[6:0]; // (RULE13)
      end
    end
  end

  // Address taken from strap once after release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0 <= `RST_PORT0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      port0[`P_ADDR] <= phy_addr_strap; // (RULE11)
      strap_done <= 1'b1;
    end else if (wr_access && idx == `IDX_PORT0) begin
      port0 <= pwdata[15:0];
    end
  end

  // Soft reset: a new write of one restarts the count, so set wins over clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      srst_active <= 1'b0;
      srst_cnt <= 4'h0;
    end else if (wr_access && idx == `IDX_CLK_CFG && pwdata[`CFG_RST]) begin
      srst_active <= 1'b1; // (RULE1)
      srst_cnt <= 4'h0;
    end else if (srst_active) begin
      srst_cnt <= srst_cnt + 4'h1;
      if (srst_cnt == `SRST_CYCLES) begin
        srst_active <= 1'b0; // (RULE1)
      end
    end
  end

  mdc_divider u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .srst(srst_active),
    .run(clk_cfg[`CFG_EN]),
    .rate(clk_cfg[`CFG_FREQ]),
    .tick_rise(tick_rise),
    .tick_fall(tick_fall),
    .mdc_level(mdc_level)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc <= 1'b0;
    end else begin
      mdc <= mdc_level && clk_cfg[`CFG_EN]; // (RULE3)
    end
  end

  // Polling engine; frames are 64 MDC cycles, data changes on MDC falling edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= mdio_pkg::ST_IDLE;
      bit_cnt <= 6'h00;
      hdr_sr <= 46'h000000000000;
      rd_sr <= 16'h0000;
      gap_cnt <= 14'h0000;
      poll_port <= 3'h6;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (srst_active || !run) begin
      state <= mdio_pkg::ST_IDLE; // (RULE1)
      bit_cnt <= 6'h00;
      gap_cnt <= 14'h0000;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0; // (RULE3)
      if (srst_active) begin
        poll_port <= 3'h6;
      end
    end else begin
      unique case (state)
        mdio_pkg::ST_IDLE: begin
          // Start on an MDC fall so the first rise samples bit 0, not bit 1
          if (|poll_en && tick_fall) begin
            poll_port <= next_port; // (RULE13)
            hdr_sr <= {`PREAMBLE, `FRAME_ST, `FRAME_RD, next_addr, `POLL_REG}; // (RULE11)
            mdio_out <= 1'b1;
            mdio_oe <= 1'b1;
            bit_cnt <= 6'h00;
            state <= mdio_pkg::ST_FRAME;
          end
        end
        mdio_pkg::ST_FRAME: begin
          if (tick_fall) begin
            hdr_sr <= {hdr_sr[44:0], 1'b0};
            mdio_out <= hdr_sr[44];
            mdio_oe <= bit_cnt < `HDR_BITS;
          end
          if (tick_rise) begin
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt >= `DATA_FIRST) begin
              rd_sr <= {rd_sr[14:0], mdio_in};
            end
            if (bit_cnt == `FRAME_LAST) begin
              gap_cnt <= 14'h0000;
              if (gap_target == 14'h0000) begin
                state <= mdio_pkg::ST_IDLE; // (RULE14)
              end else begin
                state <= mdio_pkg::ST_GAP;
              end
            end
          end
        end
        mdio_pkg::ST_GAP: begin
          if (tick_rise) begin
            gap_cnt <= gap_cnt + 14'h0001;
            if (gap_cnt + 14'h0001 >= gap_target) begin
              state <= mdio_pkg::ST_IDLE; // (RULE2)
            end
          end
        end
      endcase
    end
  end

  // Port 0 polled status; cleared while polling is off for the port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      poll_stat <= 6'h00;
    end else if (srst_active || !poll_en[0]) begin
      poll_stat <= 6'h00; // (RULE12)
    end else if (state == mdio_pkg::ST_FRAME && tick_rise && bit_cnt == `FRAME_LAST &&
                 poll_port == 3'h0) begin
      poll_stat <= {rd_sr[4:0], mdio_in};
    end
  end

  // Information source for automatic codes
  always_comb begin
    if (port0[`P_SEL]) begin
      src_link = iphy_link; // (RULE5)
      src_speed = iphy_speed;
      src_dup = iphy_duplex;
      src_txp = iphy_tx_pause;
      src_rxp = iphy_rx_pause;
    end else begin
      src_link = poll_stat[`PS_LNK]; // (RULE5)
      src_speed = poll_stat[`PS_SPD];
      src_dup = poll_stat[`PS_DUP];
      src_txp = poll_stat[`PS_TXP];
      src_rxp = poll_stat[`PS_RXP];
    end
  end

  // Reserved codes fall back to automatic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_up <= 1'b0;
      link_speed <= 2'h0;
      link_full_duplex <= 1'b0;
      tx_flow_mode <= 2'h0;
      rx_flow_mode <= 2'h0;
    end else begin
      unique case (port0[`P_LNK])
        `LNK_UP: link_up <= 1'b1; // (RULE6)
        `LNK_DOWN: link_up <= 1'b0; // (RULE6)
        default: link_up <= src_link;
      endcase
      link_speed <= (port0[`P_SPD] == `SPD_AUTO) ? src_speed : port0[`P_SPD]; // (RULE7)
      unique case (port0[`P_DUP])
        `DUP_FULL: link_full_duplex <= 1'b1; // (RULE8)
        `DUP_HALF: link_full_duplex <= 1'b0; // (RULE8)
        default: link_full_duplex <= src_dup;
      endcase
      tx_flow_mode <= flow_resolve(port0[`P_FTX], src_txp); // (RULE9)
      rx_flow_mode <= flow_resolve(port0[`P_FRX], src_rxp); // (RULE10)
    end
  end
endmodule // mdio_clock_and_link_override

/* bench/mdio_link_checker.sv */
// Port-level checks for the MDC/MDIO clock and link override block
`timescale 1ns/10ps
`include "mdio_defines.svh"
module mdio_link_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [17:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mdc,
  input wire logic mdio_oe,
  input wire logic link_up,
  input wire logic [1:0] link_speed,
  input wire logic link_full_duplex,
  input wire logic [1:0] tx_flow_mode,
  input wire logic [1:0] rx_flow_mode
);
  logic [15:0] cfg;
  logic [15:0] p0;
  logic [10:0] cfg_age;
  logic [1:0] p0_age;
  logic [10:0] hi_cnt;
  logic wr;
  logic known;
  assign wr = psel && penable && pready && pwrite;
  assign known = paddr[17:2] inside {`IDX_POLL_EN, `IDX_CLK_CFG, `IDX_PORT0, `IDX_STATUS};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Ages keep checks off while settings are still settling
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= 16'h0109;
      cfg_age <= 11'h0;
    end else if (wr && paddr[17:2] == `IDX_CLK_CFG) begin
      cfg <= pwdata[15:0];
      cfg_age <= 11'h0;
    end else begin
      cfg_age <= cfg_age + {10'h0, cfg_age != 11'h7FF};
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      p0 <= 16'h1800;
      p0_age <= 2'h0;
    end else if (wr && paddr[17:2] == `IDX_PORT0) begin
      p0 <= pwdata[15:0];
      p0_age <= 2'h0;
    end else begin
      p0_age <= p0_age + {1'b0, p0_age != 2'h3};
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) hi_cnt <= 11'h0;
    else hi_cnt <= mdc ? hi_cnt + 11'h1 : 11'h0;
  end
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_flag: assert property (psel && !penable |=> pready && pslverr == !$past(known))
    else $error("answer or error flag wrong");
  a_cfg_readback: assert property (
    pready && !pwrite && paddr[17:2] == `IDX_CLK_CFG && cfg_age >= 11'h014
    |-> prdata == {17'h0, cfg[14:0]}) else $error("clock config readback wrong");
  a_clk_off: assert property (
    !cfg[8] && cfg_age >= 11'h004 |-> !mdc && !mdio_oe) else $error("mdc or oe while disabled");
  a_mdc_high: assert property (
    $fell(mdc) && cfg_age >= 11'h5DC |-> hi_cnt == 11'h005 * ({3'h0, cfg[7:0]} + 11'h1))
    else $error("mdc high time wrong");
  a_gap_zero: assert property (
    $fell(mdio_oe) && cfg_age >= 11'h5DC && cfg[14:0] == 15'h0100
    |-> ##[170:190] $rose(mdio_oe)) else $error("next poll frame late");
  a_forced_link: assert property (
    p0_age == 2'h3 && p0[14] != p0[13] |-> link_up == p0[13]) else $error("link not forced");
  a_forced_speed: assert property (
    p0_age == 2'h3 && p0[12:11] != 2'h3 |-> link_speed == p0[12:11]) else $error("speed wrong");
  a_forced_dup: assert property (
    p0_age == 2'h3 && p0[9] |-> link_full_duplex == !p0[10]) else $error("duplex wrong");
  a_forced_tx: assert property (
    p0_age == 2'h3 && p0[7] |-> tx_flow_mode == (p0[8] ? 2'h2 : 2'h1)) else $error("tx flow wrong");
  a_forced_rx: assert property (
    p0_age == 2'h3 && p0[5] |-> rx_flow_mode == (p0[6] ? 2'h2 : 2'h1)) else $error("rx flow wrong");
  c_frame: cover property ($rose(mdio_oe));
  c_forced_up: cover property (p0_age == 2'h3 && p0[14:13] == 2'h1 && link_up);
  c_refused: cover property (pready && pslverr);
endmodule // mdio_link_checker

/* bench/phy_link_model.sv */
// External PHY answering polling reads on the management link
`timescale 1ns/10ps
module phy_link_model (
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic [5:0] status,
  output logic mdio_in,
  output logic [4:0] last_addr
);
  logic [14:0] sr = 15'h0;
  logic [4:0] cnt = 5'h0;
  logic [15:0] data;
  logic drv;
  logic wire_in;
  assign data = {10'h000, status};
  assign drv = cnt >= 5'h2 && cnt <= 5'h12;
  // Released line rests at the pull-up level
  assign mdio_in = mdio_oe ? mdio_out : (drv ? (cnt == 5'h2 ? 1'b0 : data[5'h12 - cnt]) : 1'b1);
  assign wire_in = mdio_in;
  always @(posedge mdc) begin
    sr <= {sr[13:0], wire_in};
    if (cnt != 5'h0)
      cnt <= cnt == 5'h12 ? 5'h0 : cnt + 5'h1;
    else if (sr[13:9] == 5'b10110 && {sr[3:0], wire_in} == 5'h01) begin
      last_addr <= sr[8:4];
      cnt <= 5'h1;
    end
  end
endmodule // phy_link_model

/* bench/mdio_clock_and_link_override_tb_top.sv */
// Testbench top for the MDC/MDIO clock and link override block
`timescale 1ns/10ps
`include "mdio_defines.svh"
module mdio_clock_and_link_override_tb_top;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, mdc, mdio_in, mdio_out;
  logic mdio_oe, iphy_link, iphy_duplex, iphy_tx_pause, iphy_rx_pause, link_up, link_full_duplex;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [4:0] phy_addr_strap, last_addr;
  logic [1:0] iphy_speed, link_speed, tx_flow_mode, rx_flow_mode;
  logic [2:0] poll_port;
  logic [5:0] status;
  logic [15:0] p;
  logic err;
  int miscompares = 0;
  int cmp_count = 0;
  int seed = 32'h04419F65;
  int cyc = 0;
  mdio_clock_and_link_override i_mdio_clock_and_link_override (.*);
  phy_link_model i_phy_link_model (.*);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      test_done;
    end
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits on pready; only the cycle ceiling ends a dead slave's wait
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  function automatic logic [1:0] fc(input logic [1:0] c, input logic b);
    return c == 2'h1 ? 2'h1 : c == 2'h3 ? 2'h2 : {b, b};
  endfunction
  function automatic logic [7:0] exp_link(input logic [15:0] r, input logic [5:0] s);
    return {r[14:13] == 2'h1 || (r[14:13] != 2'h2 && s[5]), r[12:11] == 2'h3 ? s[4:3] : r[12:11],
      r[10:9] == 2'h1 || (r[10:9] != 2'h3 && s[2]), fc(r[8:7], s[0]), fc(r[6:5], s[1])};
  endfunction
  task automatic check_out(input logic [5:0] s);
    chk({24'h0, link_up, link_speed, link_full_duplex, tx_flow_mode, rx_flow_mode},
      {24'h0, exp_link(p, s)});
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {iphy_link, iphy_speed, iphy_duplex, iphy_tx_pause, iphy_rx_pause} = 6'h00;
    phy_addr_strap = 5'h13;
    status = 6'h2D;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(0, `IDX_POLL_EN, 32'h0);
    chk(rdat, 32'h6F);
    apb(0, `IDX_CLK_CFG, 32'h0);
    chk(rdat, 32'h109);
    apb(0, `IDX_PORT0, 32'h0);
    chk(rdat, 32'h1813);
    apb(0, 16'h0001, 32'h0);
    chk(rdat, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset values done");
    for (int i = 0; i < 20; i++) begin
      p = 16'($random(seed));
      p[15] = 1'b1;
      if (i < 4) p = {1'b1, {5{i[1:0]}}, 5'h13};
      {iphy_link, iphy_speed, iphy_duplex, iphy_tx_pause, iphy_rx_pause} <= 6'($random(seed));
      apb(1, `IDX_PORT0, {16'h0, p});
      apb(0, `IDX_PORT0, 32'h0);
      chk(rdat, {16'h0, p});
      repeat (2) @(posedge sys_clk);
      check_out({iphy_link, iphy_speed, iphy_duplex, iphy_rx_pause, iphy_tx_pause});
    end
    $display("override codes done");
    p = 16'h180A;
    apb(1, `IDX_POLL_EN, 32'h1);
    apb(1, `IDX_PORT0, {16'h0, p});
    apb(1, `IDX_CLK_CFG, 32'h100);
    repeat (1500) @(posedge sys_clk);
    chk({27'h0, last_addr}, 32'h0A);
    check_out(status);
    apb(1, `IDX_POLL_EN, 32'h2);
    repeat (1500) @(posedge sys_clk);
    chk({27'h0, last_addr}, 32'h01);
    chk({29'h0, poll_port}, 32'h1);
    check_out(6'h00);
    $display("polling done");
    apb(1, `IDX_CLK_CFG, 32'h8100);
    apb(0, `IDX_CLK_CFG, 32'h0);
    chk(rdat, 32'h8100);
    repeat (20) @(posedge sys_clk);
    apb(0, `IDX_CLK_CFG, 32'h0);
    chk(rdat, 32'h100);
    apb(1, `IDX_CLK_CFG, 32'h0);
    repeat (5) @(posedge sys_clk);
    chk({30'h0, mdc, mdio_oe}, 32'h0);
    $display("soft reset and clock off done");
    test_done;
  end
endmodule // mdio_clock_and_link_override_tb_top
bind mdio_clock_and_link_override mdio_link_checker i_mdio_link_checker (.*);
